// *** rtl/ddrb_defines.svh ***
// constants of the two-word burst double-data-rate memory port
//------------------------------------------------------------------
//------------------------------------------------------------------
`ifndef DDRB_DEFINES_SVH
`define DDRB_DEFINES_SVH

`define DDRB_DQ_W_DEF   18
`define DDRB_AW_NARROW  20
`define DDRB_AW_WIDE36  19
`define DDRB_LANE_W8    4
`define DDRB_LANE_W     9
`define DDRB_LANES_W8   2
`define DDRB_START_W8   1'b0
`define DDRB_CNT_W      16
`define DDRB_RESET_TGL  1'b0

`endif

// *** rtl/ddrb_pkg.sv ***
// types shared by the burst memory port modules
package ddrb_pkg;
`include "ddrb_defines.svh"

  // transfer direction as sampled from the select pin
  typedef enum logic
  {
    DDRB_WRITE = 1'b0,
    DDRB_READ  = 1'b1
  } ddrb_dir_e;

  typedef logic [`DDRB_CNT_W-1:0] ddrb_cnt_t;
endpackage

// *** rtl/ddrb_store_if.sv ***
// carrier between the port control and the storage array
`timescale 1ns/1ps
interface ddrb_store_if
#(
  parameter int DQ_W  = 18,
  parameter int LOC_W = 19,
  parameter int NLANE = 2
);
  logic             wr_en;
  logic [LOC_W-1:0] wr_loc;
  logic             wr_start;
  logic [DQ_W-1:0]  wr_data0;
  logic [DQ_W-1:0]  wr_data1;
  logic [NLANE-1:0] wr_mask0_n;
  logic [NLANE-1:0] wr_mask1_n;
  logic [LOC_W-1:0] rd_loc;
  logic             rd_start;
  logic [DQ_W-1:0]  rd_data0;
  logic [DQ_W-1:0]  rd_data1;

  modport owner (output wr_en, wr_loc, wr_start, wr_data0, wr_data1,
                 wr_mask0_n, wr_mask1_n, rd_loc, rd_start,
                 input rd_data0, rd_data1);
  modport store (input wr_en, wr_loc, wr_start, wr_data0, wr_data1,
                 wr_mask0_n, wr_mask1_n, rd_loc, rd_start,
                 output rd_data0, rd_data1);
endinterface

// *** rtl/ddrb_burst_store.sv ***
// storage array holding two words per location with lane masks
`timescale 1ns/1ps
module ddrb_burst_store
#(
  parameter int DQ_W   = 18,
  parameter int LOC_W  = 19,
  parameter int NLANE  = 2,
  parameter int LANE_W = 9
)
(
  input  wire logic   link_k,
  ddrb_store_if.store st
);
  import ddrb_pkg::*;

  //------------------------------------------------------------------
  // array
  //------------------------------------------------------------------
  localparam int DEPTH = 2**(LOC_W+1);

  logic [LOC_W:0] rd_idx0;
  logic [LOC_W:0] rd_idx1;
  logic [LOC_W:0] wr_idx0;
  logic [LOC_W:0] wr_idx1;

  // the counter start word first, its linear successor second
  assign rd_idx0 = {st.rd_loc, st.rd_start};
  assign rd_idx1 = {st.rd_loc, ~st.rd_start};
  assign wr_idx0 = {st.wr_loc, st.wr_start};
  assign wr_idx1 = {st.wr_loc, ~st.wr_start};

  //------------------------------------------------------------------
  // lane-masked storage, one array and one write process per lane
  //------------------------------------------------------------------
  genvar l;
  generate
    for (l = 0; l < NLANE; l = l + 1)
    begin : g_lane
      // a private array per lane keeps every array to a single writer
      logic [LANE_W-1:0] lane_mem [0:DEPTH-1];

      // the pair is read as a whole; the counter picks the beat order
      assign st.rd_data0[l*LANE_W +: LANE_W] = lane_mem[rd_idx0];
      assign st.rd_data1[l*LANE_W +: LANE_W] = lane_mem[rd_idx1];

      // both beats land on one edge, no strobe from outside needed
      always_ff @(posedge link_k)
      begin
        if (st.wr_en && !st.wr_mask0_n[l])
          lane_mem[wr_idx0] <= st.wr_data0[l*LANE_W +: LANE_W];
        if (st.wr_en && !st.wr_mask1_n[l])
          lane_mem[wr_idx1] <= st.wr_data1[l*LANE_W +: LANE_W];
      end
    end
  endgenerate
endmodule // ddrb_burst_store

// *** rtl/ddrb_burst_port.sv ***
// two-word burst double-data-rate memory port, device side
`timescale 1ns/1ps
`include "ddrb_defines.svh"
module ddrb_burst_port
#(
  parameter int DQ_W   = `DDRB_DQ_W_DEF,
  parameter int AW     = (DQ_W == 36) ? `DDRB_AW_WIDE36
                                      : `DDRB_AW_NARROW,
  parameter int NLANE  = (DQ_W == 8) ? `DDRB_LANES_W8 : DQ_W / 9,
  parameter int LANE_W = (DQ_W == 8) ? `DDRB_LANE_W8 : `DDRB_LANE_W,
  parameter int LOC_W  = (DQ_W == 8) ? AW : AW - 1
)
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              link_k,
  input  wire logic              link_k_n,
  input  wire logic              out_c,
  input  wire logic              out_c_n,
  input  wire logic              single_clock_mode,
  input  wire logic [AW-1:0]     addr,
  input  wire logic              bus_cycle_define_n,
  input  wire logic              rd_wr_sel,
  input  wire logic [NLANE-1:0]  byte_lane_mask_n,
  input  wire logic [DQ_W-1:0]   dq_i,
  output logic      [DQ_W-1:0]   dq_o,
  output logic                   dq_oe,
  output logic                   echo_pair_p,
  output logic                   echo_pair_n,
  output ddrb_pkg::ddrb_cnt_t    rd_burst_count,
  output ddrb_pkg::ddrb_cnt_t    wr_burst_count
);
  import ddrb_pkg::*;

  //------------------------------------------------------------------
  // launch clocks
  //------------------------------------------------------------------
  logic q_clk;
  logic q_clk_n;

  // without output clocks the input pair launches the read data
  assign q_clk   = single_clock_mode ? link_k   : out_c;
  assign q_clk_n = single_clock_mode ? link_k_n : out_c_n;

  // echo pair follows the launching clocks so it tracks the data
  assign echo_pair_p = q_clk;
  assign echo_pair_n = q_clk_n;

  //------------------------------------------------------------------
  // reset release into the link domain
  //------------------------------------------------------------------
  logic rst_meta;
  logic k_rst;

  // assert at once, release on a link edge so no flop sees a runt
  always_ff @(posedge link_k or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_meta <= 1'b1;
      k_rst    <= 1'b1;
    end
    else
    begin
      rst_meta <= 1'b0;
      k_rst    <= rst_meta;
    end
  end

  //------------------------------------------------------------------
  // command input register
  //------------------------------------------------------------------
  logic             cmd_vld;
  ddrb_dir_e        cmd_dir;
  logic [LOC_W-1:0] cmd_loc;
  logic             cmd_start;
  logic             next_cmd_vld;
  ddrb_dir_e        next_cmd_dir;
  logic [LOC_W-1:0] next_cmd_loc;
  logic             next_cmd_start;

  // address and direction are only taken when a cycle is defined
  always_comb
  begin
    next_cmd_vld   = !bus_cycle_define_n;
    next_cmd_dir   = cmd_dir;
    next_cmd_loc   = cmd_loc;
    next_cmd_start = cmd_start;
    if (!bus_cycle_define_n)
    begin
      next_cmd_dir = rd_wr_sel ? DDRB_READ : DDRB_WRITE;
      if (DQ_W == 8)
      begin
        next_cmd_loc   = addr[LOC_W-1:0];
        next_cmd_start = `DDRB_START_W8;
      end
      else
      begin
        next_cmd_loc   = addr[AW-1:1];
        next_cmd_start = addr[0];
      end
    end
  end

  // sampled on the positive input rise only
  always_ff @(posedge link_k or posedge k_rst)
  begin
    if (k_rst)
    begin
      cmd_vld   <= 1'b0;
      cmd_dir   <= DDRB_WRITE;
      cmd_loc   <= '0;
      cmd_start <= 1'b0;
    end
    else
    begin
      cmd_vld   <= next_cmd_vld;
      cmd_dir   <= next_cmd_dir;
      cmd_loc   <= next_cmd_loc;
      cmd_start <= next_cmd_start;
    end
  end

  //------------------------------------------------------------------
  // storage array
  //------------------------------------------------------------------
  ddrb_store_if #(.DQ_W(DQ_W), .LOC_W(LOC_W), .NLANE(NLANE)) st ();

  ddrb_burst_store
  #(
    .DQ_W   (DQ_W),
    .LOC_W  (LOC_W),
    .NLANE  (NLANE),
    .LANE_W (LANE_W)
  )
  u_store
  (
    .link_k (link_k),
    .st     (st.store)
  );

  assign st.rd_loc   = cmd_loc;
  assign st.rd_start = cmd_start;

  //------------------------------------------------------------------
  // read stage: the pair leaves the array one rise after the command
  //------------------------------------------------------------------
  logic            rd_vld;
  logic [DQ_W-1:0] rd_w0;
  logic [DQ_W-1:0] rd_w1;
  logic            next_rd_vld;
  logic [DQ_W-1:0] next_rd_w0;
  logic [DQ_W-1:0] next_rd_w1;

  // counter start word first, its linear successor second
  always_comb
  begin
    next_rd_vld = cmd_vld && (cmd_dir == DDRB_READ);
    next_rd_w0  = rd_w0;
    next_rd_w1  = rd_w1;
    if (next_rd_vld)
    begin
      next_rd_w0 = st.rd_data0;
      next_rd_w1 = st.rd_data1;
    end
  end

  always_ff @(posedge link_k or posedge k_rst)
  begin
    if (k_rst)
    begin
      rd_vld <= 1'b0;
      rd_w0  <= '0;
      rd_w1  <= '0;
    end
    else
    begin
      rd_vld <= next_rd_vld;
      rd_w0  <= next_rd_w0;
      rd_w1  <= next_rd_w1;
    end
  end

  //------------------------------------------------------------------
  // write stage: beat 0 with its mask on the next positive rise
  //------------------------------------------------------------------
  logic             wr_vld;
  logic [LOC_W-1:0] wr_loc;
  logic             wr_start;
  logic [DQ_W-1:0]  wr_d0;
  logic [NLANE-1:0] wr_m0_n;
  logic             next_wr_vld;
  logic [LOC_W-1:0] next_wr_loc;
  logic             next_wr_start;
  logic [DQ_W-1:0]  next_wr_d0;
  logic [NLANE-1:0] next_wr_m0_n;

  // data pins are only sampled in the beat slot of a defined write
  always_comb
  begin
    next_wr_vld   = cmd_vld && (cmd_dir == DDRB_WRITE);
    next_wr_loc   = wr_loc;
    next_wr_start = wr_start;
    next_wr_d0    = wr_d0;
    next_wr_m0_n  = wr_m0_n;
    if (next_wr_vld)
    begin
      next_wr_loc   = cmd_loc;
      next_wr_start = cmd_start;
      next_wr_d0    = dq_i;
      next_wr_m0_n  = byte_lane_mask_n;
    end
  end

  always_ff @(posedge link_k or posedge k_rst)
  begin
    if (k_rst)
    begin
      wr_vld   <= 1'b0;
      wr_loc   <= '0;
      wr_start <= 1'b0;
      wr_d0    <= '0;
      wr_m0_n  <= '1;
    end
    else
    begin
      wr_vld   <= next_wr_vld;
      wr_loc   <= next_wr_loc;
      wr_start <= next_wr_start;
      wr_d0    <= next_wr_d0;
      wr_m0_n  <= next_wr_m0_n;
    end
  end

  //------------------------------------------------------------------
  // beat 1 on the negative input rise
  //------------------------------------------------------------------
  logic [DQ_W-1:0]  wr_d1;
  logic [NLANE-1:0] wr_m1_n;
  logic [DQ_W-1:0]  next_wr_d1;
  logic [NLANE-1:0] next_wr_m1_n;

  // only the rise inside a write slot samples the pins; at other rises beat 1 holds
  always_comb
  begin
    next_wr_d1   = wr_d1;
    next_wr_m1_n = wr_m1_n;
    if (wr_vld)
    begin
      next_wr_d1   = dq_i;
      next_wr_m1_n = byte_lane_mask_n;
    end
  end

  // a rising edge of the negative clock, never a falling edge
  always_ff @(posedge link_k_n or posedge k_rst)
  begin
    if (k_rst)
    begin
      wr_d1   <= '0;
      wr_m1_n <= '1;
    end
    else
    begin
      wr_d1   <= next_wr_d1;
      wr_m1_n <= next_wr_m1_n;
    end
  end

  // the whole pair lands in the array on the following positive rise
  assign st.wr_en      = wr_vld;
  assign st.wr_loc     = wr_loc;
  assign st.wr_start   = wr_start;
  assign st.wr_data0   = wr_d0;
  assign st.wr_data1   = wr_d1;
  assign st.wr_mask0_n = wr_m0_n;
  assign st.wr_mask1_n = wr_m1_n;

  //------------------------------------------------------------------
  // output registers on the launch pair
  //------------------------------------------------------------------
  logic            qp;
  logic            oep;
  logic [DQ_W-1:0] qp_d;
  logic [DQ_W-1:0] q1_hold;
  logic            oen;
  logic [DQ_W-1:0] qn_d;
  logic            next_oep;
  logic [DQ_W-1:0] next_qp_d;
  logic [DQ_W-1:0] next_q1_hold;

  // drivers fall away on the positive launch rise after the last burst
  always_comb
  begin
    next_oep     = rd_vld;
    next_qp_d    = rd_vld ? rd_w0 : qp_d;
    next_q1_hold = rd_vld ? rd_w1 : q1_hold;
  end

  always_ff @(posedge q_clk or posedge k_rst)
  begin
    if (k_rst)
    begin
      oep     <= 1'b0;
      qp_d    <= '0;
      q1_hold <= '0;
    end
    else
    begin
      oep     <= next_oep;
      qp_d    <= next_qp_d;
      q1_hold <= next_q1_hold;
    end
  end

  // second beat half a period later from the negative launch clock
  always_ff @(posedge q_clk_n or posedge k_rst)
  begin
    if (k_rst)
    begin
      oen  <= 1'b0;
      qn_d <= '0;
    end
    else
    begin
      oen  <= oep;
      qn_d <= q1_hold;
    end
  end

  // double-rate output stage; the level of the launch clock picks
  // the register, the same way a pad output pair would
  assign qp    = q_clk;
  assign dq_o  = qp ? qp_d : qn_d;
  assign dq_oe = qp ? oep : oen;

  //------------------------------------------------------------------
  // burst activity into the system clock domain
  //------------------------------------------------------------------
  logic [1:0] tgl;
  logic [1:0] next_tgl;

  // a toggle per finished burst survives while clk runs faster than the link clock
  always_comb
  begin
    next_tgl[0] = tgl[0] ^ rd_vld;
    next_tgl[1] = tgl[1] ^ wr_vld;
  end

  always_ff @(posedge link_k or posedge k_rst)
  begin
    if (k_rst)
      tgl <= {2{`DDRB_RESET_TGL}};
    else
      tgl <= next_tgl;
  end

  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] sync_c;
  ddrb_cnt_t  next_rd_cnt;
  ddrb_cnt_t  next_wr_cnt;

  // two stages before anyone looks, third stage for the edge only
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_a <= {2{`DDRB_RESET_TGL}};
      sync_b <= {2{`DDRB_RESET_TGL}};
      sync_c <= {2{`DDRB_RESET_TGL}};
    end
    else
    begin
      sync_a <= tgl;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // counters wrap; a burst every link period outruns none of them
  always_comb
  begin
    next_rd_cnt = rd_burst_count;
    next_wr_cnt = wr_burst_count;
    if (sync_b[0] != sync_c[0])
      next_rd_cnt = rd_burst_count + ddrb_cnt_t'(1);
    if (sync_b[1] != sync_c[1])
      next_wr_cnt = wr_burst_count + ddrb_cnt_t'(1);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_burst_count <= '0;
      wr_burst_count <= '0;
    end
    else
    begin
      rd_burst_count <= next_rd_cnt;
      wr_burst_count <= next_wr_cnt;
    end
  end
endmodule // ddrb_burst_port

// *** dv/ddrb_burst_port_assertions.sv ***
// concurrent checks on the burst port pins
`timescale 1ns/1ps
module ddrb_burst_port_assertions
(
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                link_k,
  input wire logic                out_c,
  input wire logic                single_clock_mode,
  input wire logic                bus_cycle_define_n,
  input wire logic                rd_wr_sel,
  input wire logic                dq_oe,
  input wire logic                echo_pair_p,
  input wire logic                echo_pair_n,
  input wire ddrb_pkg::ddrb_cnt_t rd_burst_count,
  input wire ddrb_pkg::ddrb_cnt_t wr_burst_count
);
  import ddrb_pkg::*;
  // ----------------------------------------
  // read command seen at a link rise
  // ----------------------------------------
  logic rd_cmd;
  assign rd_cmd = !bus_cycle_define_n && rd_wr_sel;

  chk_oe_reset: assert property (
    @(posedge clk) sys_rst |-> !dq_oe)
    else $error("read drivers on during reset");
  chk_cnt_clear: assert property (
    @(posedge clk) $fell(sys_rst) |-> rd_burst_count == 16'h0
      && wr_burst_count == 16'h0)
    else $error("burst counts not cleared");
  chk_rdcnt_step: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_burst_count != $past(rd_burst_count)
      |-> rd_burst_count == $past(rd_burst_count) + 16'h1)
    else $error("read count jumped");
  chk_wrcnt_step: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_burst_count != $past(wr_burst_count)
      |-> wr_burst_count == $past(wr_burst_count) + 16'h1)
    else $error("write count jumped");
  chk_echo_comp: assert property (
    @(posedge clk) disable iff (sys_rst) echo_pair_n == !echo_pair_p)
    else $error("echo pair not complementary");
  chk_echo_single: assert property (
    @(posedge clk) disable iff (sys_rst)
    single_clock_mode |-> echo_pair_p == link_k)
    else $error("echo not on input clock");
  chk_echo_split: assert property (
    @(posedge clk) disable iff (sys_rst)
    !single_clock_mode |-> echo_pair_p == out_c)
    else $error("echo not on output clock");
  chk_read_window: assert property (
    @(posedge link_k) disable iff (sys_rst)
    single_clock_mode |-> dq_oe == $past(rd_cmd, 3))
    else $error("read drive window wrong");
  chk_read_split: assert property (
    @(posedge link_k) disable iff (sys_rst)
    !single_clock_mode |-> dq_oe == $past(rd_cmd, 2))
    else $error("split clock drive window wrong");
endmodule // ddrb_burst_port_assertions

bind ddrb_burst_port ddrb_burst_port_assertions u_chk
(
  .clk                (clk),
  .sys_rst            (sys_rst),
  .link_k             (link_k),
  .out_c              (out_c),
  .single_clock_mode  (single_clock_mode),
  .bus_cycle_define_n (bus_cycle_define_n),
  .rd_wr_sel          (rd_wr_sel),
  .dq_oe              (dq_oe),
  .echo_pair_p        (echo_pair_p),
  .echo_pair_n        (echo_pair_n),
  .rd_burst_count     (rd_burst_count),
  .wr_burst_count     (wr_burst_count)
);

// *** dv/ddrb_ctrl_model.sv ***
// memory controller model on the far side of the port
`timescale 1ns/1ps
module ddrb_ctrl_model
#(
  parameter int DQ_W  = 18,
  parameter int AW    = 20,
  parameter int NLANE = 2
)
(
  input  wire logic             link_k,
  input  wire logic [DQ_W-1:0]  dq_o,
  input  wire logic             dq_oe,
  output logic      [AW-1:0]    addr,
  output logic                  bus_cycle_define_n,
  output logic                  rd_wr_sel,
  output logic      [NLANE-1:0] byte_lane_mask_n,
  output logic      [DQ_W-1:0]  dq_drv
);
  // ----------------------------------------
  // idle bus at time zero
  // ----------------------------------------
  initial
  begin
    addr               = '0;
    bus_cycle_define_n = 1'b1;
    rd_wr_sel          = 1'b0;
    byte_lane_mask_n   = '1;
    dq_drv             = '0;
  end

  // released lines flip so stale values never look valid
  task automatic cmd(input logic [AW-1:0] a, input logic rd);
    @(posedge link_k);
    bus_cycle_define_n <= 1'b0;
    rd_wr_sel          <= rd;
    addr               <= a;
    @(posedge link_k);
    bus_cycle_define_n <= 1'b1;
    rd_wr_sel          <= ~rd;
    addr               <= ~a;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DQ_W-1:0] d0,
                    d1, input logic [NLANE-1:0] m0, m1);
    cmd(a, 1'b0);
    dq_drv           <= d0;
    byte_lane_mask_n <= m0;
    @(posedge link_k);
    dq_drv           <= d1;
    byte_lane_mask_n <= m1;
    @(negedge link_k);
    dq_drv           <= ~d1;
    byte_lane_mask_n <= ~m1;
  endtask

  // sh places the sample mid-word for the chosen launch clock
  task automatic rd(input logic [AW-1:0] a, input int sh,
                    output logic [DQ_W-1:0] w0, w1, output logic oe);
    cmd(a, 1'b1);
    @(posedge link_k);
    #(sh);
    w0 = dq_o;
    oe = dq_oe;
    #40;
    w1 = dq_o;
  endtask

  // one rise of free traffic, back to back allowed
  task automatic pulse(input logic go, rw, input logic [AW-1:0] a);
    @(posedge link_k);
    bus_cycle_define_n <= ~go;
    rd_wr_sel          <= rw;
    addr               <= a;
    dq_drv             <= DQ_W'(a);
    byte_lane_mask_n   <= '0;
  endtask
endmodule // ddrb_ctrl_model

// *** dv/test_ddrb_burst_port.sv ***
// self-checking bench for the burst memory port
`timescale 1ns/1ps
module test_ddrb_burst_port;
  localparam int DW = 18;
  logic                clk;
  logic                sys_rst;
  logic                link_k;
  wire logic           out_c;
  logic                single_clock_mode;
  logic [19:0]         addr;
  logic                bus_cycle_define_n;
  logic                rd_wr_sel;
  logic [1:0]          byte_lane_mask_n;
  logic [DW-1:0]       dq_o;
  logic [DW-1:0]       dq_drv;
  logic                dq_oe;
  logic                echo_pair_p;
  logic                echo_pair_n;
  ddrb_pkg::ddrb_cnt_t rd_burst_count;
  ddrb_pkg::ddrb_cnt_t wr_burst_count;
  logic [DW-1:0]       mem [int];
  int                  failures;
  int                  num_checks;
  int                  seed;
  int                  n_rd;
  int                  n_wr;
  // ----------------------------------------
  // clocks, pins and instances
  // ----------------------------------------
  wire logic [DW-1:0] dq_i = dq_oe ? dq_o : dq_drv;
  assign #10 out_c = link_k;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // link clock offset so its edges never meet clk edges
  initial
  begin
    link_k = 1'b0;
    #3;
    forever #40 link_k = ~link_k;
  end

  ddrb_burst_port dut
  (
    .clk (clk), .sys_rst (sys_rst), .link_k (link_k),
    .link_k_n (~link_k), .out_c (out_c), .out_c_n (~out_c),
    .single_clock_mode (single_clock_mode), .addr (addr),
    .bus_cycle_define_n (bus_cycle_define_n), .rd_wr_sel (rd_wr_sel),
    .byte_lane_mask_n (byte_lane_mask_n), .dq_i (dq_i), .dq_o (dq_o),
    .dq_oe (dq_oe), .echo_pair_p (echo_pair_p),
    .echo_pair_n (echo_pair_n), .rd_burst_count (rd_burst_count),
    .wr_burst_count (wr_burst_count)
  );

  ddrb_ctrl_model u_ctrl
  (
    .link_k (link_k), .dq_o (dq_o), .dq_oe (dq_oe), .addr (addr),
    .bus_cycle_define_n (bus_cycle_define_n), .rd_wr_sel (rd_wr_sel),
    .byte_lane_mask_n (byte_lane_mask_n), .dq_drv (dq_drv)
  );

  // lane merge: a low mask bit lets that nine-bit lane through
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, nw,
                                          input logic [1:0] m);
    merge = old;
    for (int i = 0; i < 2; i++)
      if (!m[i]) merge[i*9 +: 9] = nw[i*9 +: 9];
  endfunction

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_wr(input logic [19:0] a, input logic [DW-1:0] d0, d1,
                       input logic [1:0] m0, m1);
    u_ctrl.wr(a, d0, d1, m0, m1);
    n_wr++;
    if (!mem.exists(a)) mem[a] = '0;
    if (!mem.exists(a ^ 20'h1)) mem[a ^ 20'h1] = '0;
    mem[a] = merge(mem[a], d0, m0);
    mem[a ^ 20'h1] = merge(mem[a ^ 20'h1], d1, m1);
  endtask

  task automatic do_rd(input logic [19:0] a, input int sh);
    logic [DW-1:0] w0;
    logic [DW-1:0] w1;
    logic          oe;
    u_ctrl.rd(a, sh, w0, w1, oe);
    n_rd++;
    check("drive", oe, 1'b1);
    check("word0", w0, mem[a]);
    check("word1", w1, mem[a ^ 20'h1]);
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    conclude();
  end

  // main sequence
  initial
  begin
    logic [19:0] a;
    logic [1:0]  m0;
    logic [1:0]  m1;
    logic        go;
    logic        rw;
    failures = 0;
    num_checks = 0;
    seed = 64594;
    n_rd = 0;
    n_wr = 0;
    sys_rst = 1'b0;
    #1;
    sys_rst = 1'b1;
    single_clock_mode = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge link_k);
    // full write, masked rewrite, read from either start word
    for (int i = 0; i < 14; i++)
    begin
      a = 20'($random(seed));
      if (i == 4) a = '1;
      if (i == 5) a = '0;
      m0 = (i < 4) ? 2'(i) : 2'($random(seed));
      m1 = (i < 4) ? 2'(3 - i) : 2'($random(seed));
      do_wr(a, DW'($random(seed)), DW'($random(seed)), 2'b00, 2'b00);
      do_wr(a ^ 20'(i % 2), DW'($random(seed)), DW'($random(seed)),
            m0, m1);
      do_rd(a ^ 20'($random(seed) & 1), 100);
    end
    $display("test data done");
    // let the last single-clock burst drain before the strap moves
    repeat (2) @(posedge link_k);
    @(posedge clk);
    single_clock_mode <= 1'b0;
    repeat (3) @(posedge link_k);
    do_rd(a, 30);
    repeat (3) @(posedge link_k);
    @(posedge clk);
    single_clock_mode <= 1'b1;
    repeat (3) @(posedge link_k);
    $display("test split clock done");
    // random back-to-back traffic with idle rises mixed in
    for (int i = 0; i < 60; i++)
    begin
      go = 1'($random(seed));
      rw = 1'($random(seed));
      u_ctrl.pulse(go, rw, 20'($random(seed)));
      n_rd += int'(go & rw);
      n_wr += int'(go & !rw);
    end
    u_ctrl.pulse(1'b0, 1'b0, 20'h0);
    for (int t = 0; t < 200 && (rd_burst_count !== 16'(n_rd)
         || wr_burst_count !== 16'(n_wr)); t++)
      @(posedge clk);
    check("reads", rd_burst_count, n_rd);
    check("writes", wr_burst_count, n_wr);
    $display("test traffic done");
    conclude();
  end
endmodule // test_ddrb_burst_port
